// *** logic/fccu_pkg.sv ***
// What this block does
// - Interrupt on entering read/write result phase
// - Interrupt when seek, relative seek, recalibrate end
// - Interrupt per byte in non-DMA execution
// - Sense interrupt clears interrupt, reports cause
// - Cause codes: poll 0/11, normal 1/00, abnormal 1/01
// - Head bit reads zero in sense status
// - Host senses interrupt after every seek
// - Drive status sense skips execution phase
// - Head unload delay 16n ms, code 0 256
// - Step interval 16-n ms, scaled by rate
// - Head load delay 2n ms, code 0 256
// - Non-DMA bit picks ready bit or DMA request
// - Implied seek before read/write when enabled
// - FIFO disabled by default, byte transfers
// - One poll interrupt after reset, not loaded
// - FIFO threshold 1 to 16, default 1
// - Precomp start track 0 to 255, default 0
// - Version command returns one fixed byte
// - Relative seek steps count, bit selects direction
// - Cylinder becomes old plus count (inward) or minus count (outward) mod 256
// - Only one relative seek at a time
// - Equipment check when stepping out past track 0
package fccu_pkg;
  // Register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_DATA   = 4'h4;
  localparam logic [3:0] REG_CONFIG = 4'h8;
  // Opcodes
  localparam logic [7:0] OP_SPECIFY   = 8'h03;
  localparam logic [7:0] OP_SENSE_DRV = 8'h04;
  localparam logic [7:0] OP_RECAL     = 8'h07;
  localparam logic [7:0] OP_SENSE_INT = 8'h08;
  localparam logic [7:0] OP_SEEK      = 8'h0F;
  localparam logic [7:0] OP_VERSION   = 8'h10;
  localparam logic [7:0] OP_CONFIGURE = 8'h13;
  localparam logic [5:0] REL_SEEK_LOW = 6'h0F;
  // Termination codes
  localparam logic [1:0] TC_NORMAL   = 2'h0;
  localparam logic [1:0] TC_ABNORMAL = 2'h1;
  localparam logic [1:0] TC_INVALID  = 2'h2;
  localparam logic [1:0] TC_POLL     = 2'h3;
  // Configure byte field positions
  localparam int CFG_ISEEK_BIT    = 6;
  localparam int CFG_FIFO_OFF_BIT = 5;
  localparam int CFG_POLL_BIT     = 4;
  // Reset values
  localparam logic       RST_ISEEK    = 1'h0;
  localparam logic       RST_FIFO_OFF = 1'h1;
  localparam logic       RST_POLL     = 1'h0;
  localparam logic [3:0] RST_THR      = 4'h0;
  localparam logic [7:0] RST_PRECOMP  = 8'h00;
  localparam logic [3:0] RST_CODE   = 4'h0;
  // Timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int UNIT_TIME_NS    = 1000000;
  localparam int UNIT_CYCLES     = (UNIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_PULSE_NS   = 3000;
  localparam int STEP_PULSE_CYC  = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_BASE       = 16;
  localparam int UNLOAD_SCALE    = 16;
  localparam int LOAD_SCALE      = 2;
  localparam int CODE0_UNITS     = 256;
  localparam int RECAL_MAX_STEPS = 79;
  // Data rate select
  typedef enum logic [2:0] {
    RATE_500K = 3'h0, RATE_300K = 3'h1, RATE_250K = 3'h2, RATE_1M = 3'h3, RATE_2M = 3'h4
  } fccu_rate_t;
  // Configuration carried to the data path
  typedef struct packed {
    logic       implied_seek_enable;
    logic       fifo_disable;
    logic       poll_disable;
    logic       pio_transfer_select;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
  } fccu_cfg_t;
endpackage : fccu_pkg

// *** logic/fccu_top.sv ***
`timescale 1ns/1ps
module fccu_top #(
  parameter int         UNIT_CYCLES  = fccu_pkg::UNIT_CYCLES,
  parameter logic [7:0] VERSION_CODE = 8'hA5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  // Data path handshake, same clock
  input  wire fccu_pkg::fccu_rate_t rate_sel,
  input  wire logic                rw_exec_start,
  input  wire logic [7:0]          rw_cyl,
  input  wire logic                rw_exec_end,
  input  wire logic                rw_result_enter,
  input  wire logic                rw_byte_need,
  input  wire logic                rw_byte_done,
  output logic                     rw_go,
  output fccu_pkg::fccu_cfg_t      cfg,
  output logic                     host_transfer_ready,
  output logic                     disk_dma_request,
  output logic                     irq,
  // Drive pins
  input  wire logic                track0_n,
  input  wire logic                write_protect_n,
  output logic                     step,
  output logic                     step_dir,
  output logic                     head_load
);
  generate
    if (UNIT_CYCLES < 8) begin : g_chk
      $error("UNIT_CYCLES too small");
    end
  endgenerate

  localparam int TW = $clog2(UNIT_CYCLES * 2 + 1);

  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_PARAM = 2'h1, S_EXEC = 2'h2, S_RESULT = 2'h3
  } fccu_cst_t;
  typedef enum logic [1:0] {K_ABS = 2'h0, K_REL = 2'h1, K_RECAL = 2'h2} fccu_kind_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_SKREQ = 3'h1, H_SKWAIT = 3'h2, H_LOAD = 3'h3, H_RUN = 3'h4, H_UNLOAD = 3'h5
  } fccu_hst_t;

  fccu_cst_t  st;                 // Command phase
  fccu_kind_t sk_kind;            // Running seek type
  fccu_hst_t  hl;                 // Head state
  logic [7:0] op;                 // Latched opcode
  logic [7:0] prm [3];            // Parameter bytes
  logic [1:0] pidx, need;         // Parameter count
  logic [7:0] res0, res1;         // Result bytes
  logic [1:0] rcnt, ridx;         // Result count, read index
  logic [3:0] step_code, unload_code; // Timing codes
  logic [6:0] load_code;
  logic [TW-1:0] tick_cnt, tick_per;
  logic tick;
  logic [1:0] trk_s, wp_s;        // Pin synchronisers
  logic       at_trk0, wprot;
  logic [7:0] present_cylinder, sk_target, sk_left, exp_cylinder;
  logic [8:0] sk_wait, hl_wait;
  logic [7:0] pul_cnt;
  logic sk_busy, sk_imp, sk_done, sk_done_imp, sk_eqchk;
  logic [1:0] sk_term;
  logic seek_pend, poll_pend, poll_done, pio_pend;
  logic is_rel, exec, cmd_seek_go, imp_go, sense_int, data_wr, data_rd;

  // Parameter count per opcode
  function automatic logic [1:0] nparams(input logic [7:0] o);
    if (o[7] && o[5:0] == fccu_pkg::REL_SEEK_LOW) return 2'h2;
    case (o)
      fccu_pkg::OP_SPECIFY, fccu_pkg::OP_SEEK: return 2'h2;
      fccu_pkg::OP_SENSE_DRV, fccu_pkg::OP_RECAL: return 2'h1;
      fccu_pkg::OP_CONFIGURE: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  // Decoded strobes
  assign is_rel    = op[7] && op[5:0] == fccu_pkg::REL_SEEK_LOW;
  assign exec      = st == S_EXEC;
  assign sense_int = exec && op == fccu_pkg::OP_SENSE_INT;
  assign data_wr   = reg_wr && reg_addr == fccu_pkg::REG_DATA;
  assign data_rd   = reg_rd && reg_addr == fccu_pkg::REG_DATA;
  // Seeks refused while the engine is busy
  assign cmd_seek_go = exec && !sk_busy && (is_rel || op == fccu_pkg::OP_SEEK ||
                       op == fccu_pkg::OP_RECAL);
  assign imp_go = hl == H_SKREQ && !sk_busy && !cmd_seek_go;

  // Two-flop pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trk_s <= 2'h3;
      wp_s  <= 2'h3;
    end else begin
      trk_s <= {trk_s[0], track0_n};
      wp_s  <= {wp_s[0], write_protect_n};
    end
  end
  assign at_trk0 = !trk_s[1];
  assign wprot   = !wp_s[1];

  // Unit period per data rate
  always_comb begin
    case (rate_sel)
      fccu_pkg::RATE_2M:   tick_per = TW'(UNIT_CYCLES / 4 - 1);
      fccu_pkg::RATE_1M:   tick_per = TW'(UNIT_CYCLES / 2 - 1);
      fccu_pkg::RATE_300K: tick_per = TW'(UNIT_CYCLES * 5 / 3 - 1);
      fccu_pkg::RATE_250K: tick_per = TW'(UNIT_CYCLES * 2 - 1);
      default:             tick_per = TW'(UNIT_CYCLES - 1);
    endcase
  end

  // Free running unit tick, scales step, load and unload delays with rate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt >= tick_per) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // Command, parameter and result phases
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st   <= S_IDLE;
      op   <= 8'h00;
      pidx <= 2'h0;
      need <= 2'h0;
      ridx <= 2'h0;
      for (int i = 0; i < 3; i++) prm[i] <= 8'h00;
    end else begin
      case (st)
        S_IDLE: if (data_wr) begin
          op   <= reg_wdata;
          need <= nparams(reg_wdata);
          pidx <= 2'h0;
          st   <= nparams(reg_wdata) == 2'h0 ? S_EXEC : S_PARAM;
        end
        S_PARAM: if (data_wr) begin
          prm[pidx] <= reg_wdata;
          pidx      <= pidx + 1'b1;
          if (pidx == need - 1'b1) st <= S_EXEC;
        end
        S_EXEC: begin
          // Drive status and others go straight to results
          ridx <= 2'h0;
          st   <= nparams(op) == 2'h0 && op != fccu_pkg::OP_SENSE_INT &&
                  op != fccu_pkg::OP_VERSION ? S_RESULT :
                  (op == fccu_pkg::OP_SENSE_INT || op == fccu_pkg::OP_VERSION ||
                   op == fccu_pkg::OP_SENSE_DRV) ? S_RESULT : S_IDLE;
        end
        S_RESULT: if (data_rd) begin
          ridx <= ridx + 1'b1;
          if (ridx + 1'b1 == rcnt) st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // Result bytes built in the execute cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res0 <= 8'h00;
      res1 <= 8'h00;
      rcnt <= 2'h0;
    end else if (exec) begin
      res1 <= present_cylinder;
      rcnt <= 2'h1;
      case (op)
        fccu_pkg::OP_SENSE_INT: begin
          rcnt <= seek_pend || poll_pend ? 2'h2 : 2'h1;
          if (seek_pend) res0 <= {sk_term, 1'b1, sk_eqchk, 4'h0};
          else if (poll_pend) res0 <= {fccu_pkg::TC_POLL, 6'h00};
          else res0 <= {fccu_pkg::TC_INVALID, 6'h00};
        end
        fccu_pkg::OP_SENSE_DRV:
          res0 <= {1'b0, wprot, 1'b1, at_trk0, 1'b1, prm[0][2], prm[0][1:0]};
        fccu_pkg::OP_VERSION: res0 <= VERSION_CODE;
        default: res0 <= {fccu_pkg::TC_INVALID, 6'h00};
      endcase
    end
  end

  // Specify and configure settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_code   <= fccu_pkg::RST_CODE;
      unload_code <= fccu_pkg::RST_CODE;
      load_code   <= 7'h00;
      cfg      <= '{fccu_pkg::RST_ISEEK, fccu_pkg::RST_FIFO_OFF, fccu_pkg::RST_POLL, 1'b0,
                    fccu_pkg::RST_THR, fccu_pkg::RST_PRECOMP};
    end else if (exec && op == fccu_pkg::OP_SPECIFY) begin
      step_code   <= prm[0][7:4];
      unload_code <= prm[0][3:0];
      load_code   <= prm[1][7:1];
      cfg.pio_transfer_select <= prm[1][0];
    end else if (exec && op == fccu_pkg::OP_CONFIGURE) begin
      cfg.implied_seek_enable <= prm[1][fccu_pkg::CFG_ISEEK_BIT];
      cfg.fifo_disable        <= prm[1][fccu_pkg::CFG_FIFO_OFF_BIT];
      cfg.poll_disable        <= prm[1][fccu_pkg::CFG_POLL_BIT];
      cfg.fifo_threshold      <= prm[1][3:0];
      cfg.precomp_start_track <= prm[2];
    end
  end

  // Seek engine: absolute, relative, recalibrate, implied
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sk_busy <= 1'b0; sk_imp <= 1'b0; sk_done <= 1'b0; sk_done_imp <= 1'b0;
      sk_kind <= K_ABS; sk_target <= 8'h00; sk_left <= 8'h00; sk_wait <= 9'h000;
      sk_term <= fccu_pkg::TC_NORMAL; sk_eqchk <= 1'b0;
      present_cylinder <= 8'h00; exp_cylinder <= 8'h00;
      step <= 1'b0; step_dir <= 1'b0; pul_cnt <= 8'h00;
    end else begin
      sk_done     <= 1'b0;
      sk_done_imp <= 1'b0;
      if (cmd_seek_go || imp_go) begin
        sk_busy   <= 1'b1;
        sk_imp    <= imp_go;
        sk_wait   <= 9'h000;
        sk_target <= imp_go ? rw_cyl : prm[1];
        sk_kind   <= imp_go || op == fccu_pkg::OP_SEEK ? K_ABS : is_rel ? K_REL : K_RECAL;
        sk_left   <= is_rel ? prm[1] : 8'(fccu_pkg::RECAL_MAX_STEPS);
        step_dir  <= is_rel && op[6];
        exp_cylinder <= op[6] ? present_cylinder + prm[1] : present_cylinder - prm[1];
        if (!imp_go && op == fccu_pkg::OP_RECAL) present_cylinder <= 8'h00;
      end else if (pul_cnt != 8'h00) begin
        pul_cnt <= pul_cnt - 1'b1;
        if (pul_cnt == 8'h01) step <= 1'b0;
      end else if (sk_wait != 9'h000) begin
        if (tick) sk_wait <= sk_wait - 1'b1;
      end else if (sk_busy) begin
        // Either finish or issue one more step
        if ((sk_kind == K_ABS && present_cylinder == sk_target) ||
            (sk_kind == K_REL && sk_left == 8'h00) || (sk_kind == K_RECAL && at_trk0)) begin
          sk_busy <= 1'b0;
          sk_done <= !sk_imp;
          sk_done_imp <= sk_imp;
          sk_term <= fccu_pkg::TC_NORMAL;
          sk_eqchk <= 1'b0;
        end else if ((sk_kind == K_REL && !step_dir && at_trk0) ||
                     (sk_kind == K_RECAL && sk_left == 8'h00)) begin
          sk_busy <= 1'b0;
          sk_done <= !sk_imp;
          sk_term  <= fccu_pkg::TC_ABNORMAL;
          sk_eqchk <= 1'b1;
        end else begin
          step    <= 1'b1;
          pul_cnt <= 8'(fccu_pkg::STEP_PULSE_CYC);
          sk_wait <= step_code == 4'h0 ? 9'(fccu_pkg::STEP_BASE) :
                     9'(fccu_pkg::STEP_BASE) - {5'h00, step_code};
          if (sk_kind != K_REL) sk_left <= sk_left - 1'b1;
          else sk_left <= sk_left - 1'b1;
          if (sk_kind == K_ABS) step_dir <= present_cylinder < sk_target;
          if (sk_kind == K_RECAL) step_dir <= 1'b0;
          // Wraps modulo 256, no compare for relative
          if (sk_kind == K_RECAL) present_cylinder <= 8'h00;
          else if (sk_kind == K_ABS ? present_cylinder < sk_target : step_dir)
            present_cylinder <= present_cylinder + 1'b1;
          else present_cylinder <= present_cylinder - 1'b1;
        end
      end
    end
  end

  // Head load, implied seek and head unload timing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hl <= H_IDLE; hl_wait <= 9'h000; head_load <= 1'b0; rw_go <= 1'b0;
    end else begin
      rw_go <= 1'b0;
      case (hl)
        H_IDLE, H_UNLOAD: begin
          if (hl == H_UNLOAD && tick && hl_wait != 9'h000) hl_wait <= hl_wait - 1'b1;
          if (rw_exec_start) begin
            if (cfg.implied_seek_enable && present_cylinder != rw_cyl) hl <= H_SKREQ;
            else if (head_load) begin
              hl <= H_RUN;
              rw_go <= 1'b1;
            end else hl <= H_LOAD;
            hl_wait <= load_code == 7'h00 ? 9'(fccu_pkg::CODE0_UNITS) :
                       9'(fccu_pkg::LOAD_SCALE) * {2'h0, load_code};
          end else if (hl == H_UNLOAD && hl_wait == 9'h000) begin
            head_load <= 1'b0;
            hl <= H_IDLE;
          end
        end
        H_SKREQ: if (imp_go) hl <= H_SKWAIT;
        H_SKWAIT: if (sk_done_imp) hl <= head_load ? H_RUN : H_LOAD;
        H_LOAD: begin
          head_load <= 1'b1;
          if (tick && hl_wait != 9'h000) hl_wait <= hl_wait - 1'b1;
          if (hl_wait == 9'h000) begin
            rw_go <= 1'b1;
            hl <= H_RUN;
          end
        end
        H_RUN: if (rw_exec_end) begin
          hl <= H_UNLOAD;
          hl_wait <= unload_code == 4'h0 ? 9'(fccu_pkg::CODE0_UNITS) :
                     9'(fccu_pkg::UNLOAD_SCALE) * {5'h00, unload_code};
        end
        default: hl <= H_IDLE;
      endcase
    end
  end

  // Pending causes, polling after reset; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seek_pend <= 1'b0; poll_pend <= 1'b0; poll_done <= 1'b0;
    end else begin
      if (sk_done) seek_pend <= 1'b1;
      else if (sense_int) seek_pend <= 1'b0;
      if (!cfg.poll_disable && !poll_done && !head_load) begin
        poll_pend <= 1'b1;
        poll_done <= 1'b1;
      end else if (sense_int && !seek_pend) poll_pend <= 1'b0;
    end
  end

  // Interrupt line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else if (sk_done || rw_result_enter || (rw_byte_need && cfg.pio_transfer_select) ||
             (!cfg.poll_disable && !poll_done && !head_load)) irq <= 1'b1;
    else if (sense_int || (rw_byte_done && cfg.pio_transfer_select)) irq <= 1'b0;
  end

  // Byte transfer signalling per mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pio_pend <= 1'b0; disk_dma_request <= 1'b0; host_transfer_ready <= 1'b0;
    end else begin
      if (rw_byte_need && cfg.pio_transfer_select) pio_pend <= 1'b1;
      else if (rw_byte_done) pio_pend <= 1'b0;
      if (rw_byte_need && !cfg.pio_transfer_select) disk_dma_request <= 1'b1;
      else if (rw_byte_done) disk_dma_request <= 1'b0;
      host_transfer_ready <= st != S_EXEC || pio_pend;
    end
  end

  // Register read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == fccu_pkg::REG_STATUS)
      reg_rdata <= {host_transfer_ready, st == S_RESULT, pio_pend, st != S_IDLE,
                    sk_busy, head_load, 2'h0};
    else if (data_rd && st == S_RESULT) reg_rdata <= ridx == 2'h0 ? res0 : res1;
    else if (reg_rd && reg_addr == fccu_pkg::REG_CONFIG) reg_rdata <= present_cylinder;
    else reg_rdata <= 8'h00;
  end

  // Checks
  property p_sense_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    sense_int && !sk_done && !rw_result_enter && !rw_byte_need && poll_done |=> !irq;
  endproperty
  a_sense_clr: assert property (p_sense_clr) else $error("irq not cleared");
  property p_seek_irq;
    @(posedge ref_clk) disable iff (!rst_n) sk_done |=> irq ##0 seek_pend;
  endproperty
  a_seek_irq: assert property (p_seek_irq) else $error("no seek irq");
  property p_res_irq;
    @(posedge ref_clk) disable iff (!rst_n) rw_result_enter |=> irq;
  endproperty
  a_res_irq: assert property (p_res_irq) else $error("no result irq");
  property p_pio;
    @(posedge ref_clk) disable iff (!rst_n)
    rw_byte_need && cfg.pio_transfer_select |=> irq && pio_pend && !disk_dma_request[*1];
  endproperty
  a_pio: assert property (p_pio) else $error("pio signalling wrong");
  property p_drv;
    @(posedge ref_clk) disable iff (!rst_n)
    exec && op == fccu_pkg::OP_SENSE_DRV |=> st == S_RESULT && rcnt == 2'h1;
  endproperty
  a_drv: assert property (p_drv) else $error("drive sense not direct");
  property p_ver;
    @(posedge ref_clk) disable iff (!rst_n)
    exec && op == fccu_pkg::OP_VERSION |=> res0 == VERSION_CODE ##1 st == S_RESULT;
  endproperty
  a_ver: assert property (p_ver) else $error("bad version byte");
  property p_rel_cyl;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(sk_busy) && sk_kind == K_REL && sk_term == fccu_pkg::TC_NORMAL |->
      present_cylinder == exp_cylinder;
  endproperty
  a_rel_cyl: assert property (p_rel_cyl) else $error("relative cylinder wrong");
  property p_head0;
    @(posedge ref_clk) disable iff (!rst_n)
    sense_int && seek_pend |=> res0[2] == 1'b0 && res0[5];
  endproperty
  a_head0: assert property (p_head0) else $error("head bit set");
endmodule : fccu_top

// *** verif/fccu_drive_model.sv ***
`timescale 1ns/1ps
module fccu_drive_model #(
  parameter int START_CYL = 3  // Head position at power-up
) (
  // Step interface from the controller
  input  wire logic step,
  input  wire logic step_dir,
  // Status pins back to the controller
  output logic      track0_n,
  output logic      write_protect_n
);
  // Physical head position, not wrapped at 255
  int pos = START_CYL;
  // One track per step pulse; outward stops at the mechanical end
  always @(posedge step) begin
    if (step_dir) begin
      pos <= pos + 1;
    end else if (pos > 0) begin
      pos <= pos - 1;
    end
  end
  // Track zero sensor, active low
  assign track0_n = (pos != 0);
  // Medium always write protected
  assign write_protect_n = 1'b0;
endmodule : fccu_drive_model

// *** verif/fccu_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module fccu_top_tb;
  localparam logic [3:0] DR = fccu_pkg::REG_DATA;  // Command and result port
  logic [3:0] reg_addr;             // Register offset
  logic [7:0] reg_wdata, reg_rdata; // Register data
  logic       ref_clk, rst_n, reg_wr, reg_rd;
  logic [4:0] ev;                   // Start, end, result, need, done pulses
  logic       rw_go, host_transfer_ready, disk_dma_request, irq;
  logic       track0_n, write_protect_n, step, step_dir, head_load;
  fccu_pkg::fccu_cfg_t cfg;         // Live configuration
  logic [7:0] st, cy, d;            // Results
  logic [7:0] cyl;                  // Cylinder of a read/write start
  int         n, fail_count, comparisons;

  fccu_top #(.UNIT_CYCLES(16), .VERSION_CODE(8'h5A)) u_fccu_top (  // Arbitrary code
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rate_sel(fccu_pkg::RATE_500K), .rw_exec_start(ev[0]), .rw_cyl(cyl),
    .rw_exec_end(ev[1]), .rw_result_enter(ev[2]), .rw_byte_need(ev[3]),
    .rw_byte_done(ev[4]), .rw_go(rw_go), .cfg(cfg), .irq(irq),
    .host_transfer_ready(host_transfer_ready), .disk_dma_request(disk_dma_request),
    .track0_n(track0_n), .write_protect_n(write_protect_n), .step(step),
    .step_dir(step_dir), .head_load(head_load));
  fccu_drive_model u_fccu_drive_model (
    .step(step), .step_dir(step_dir), .track0_n(track0_n),
    .write_protect_n(write_protect_n));

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= DR;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Register read after a short settle, data taken in the next cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    repeat (2) @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask : rd
  // One-cycle pulse on a data path input
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev <= '0;
    repeat (2) @(negedge ref_clk);
  endtask : pulse
  // Bounded wait for irq or rw_go
  task automatic wait_hi(input bit go, input int lim);
    n = 0;
    while ((go ? rw_go : irq) !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= lim) fail_count++;
  endtask : wait_hi
  // Wait for seek end, then interrupt sense
  task automatic seek_end;
    wait_hi(0, 15000);
    wr(fccu_pkg::OP_SENSE_INT);
    rd(DR, st);
    rd(DR, cy);
  endtask : seek_end
  // Reset, defaults, single poll interrupt
  task automatic boot;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK(cfg, 16'h4000)
    rst_n <= 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(irq, 1'b1)
    seek_end();
    `CHK(st, 8'hC0)
    repeat (50) @(negedge ref_clk);
    `CHK(irq, 1'b0)
  endtask : boot
  // Verdict
  task automatic final_report;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
    cyl = 8'h04;
    boot();
    wr(fccu_pkg::OP_VERSION);
    rd(DR, d);
    `CHK(d, 8'h5A)
    wr(fccu_pkg::OP_SPECIFY);
    wr(8'hF1);
    wr(8'h02);
    for (int k = 0; k < 2; k++) begin
      wr(fccu_pkg::OP_RECAL);
      wr(8'h00);
      seek_end();
      `CHK({st, cy}, 16'h2000)
      if (k == 0) begin
        wr(8'h8F);  // Relative seek outward past track zero
        wr(8'h00);
        wr(8'h02);
        seek_end();
        `CHK(st, 8'h70)
      end
    end
    wr(fccu_pkg::OP_SENSE_DRV);
    wr(8'h00);
    rd(DR, d);
    `CHK(d, 8'h78)
    wr(fccu_pkg::OP_SEEK);
    wr(8'h00);
    wr(8'h05);
    seek_end();
    `CHK({st, cy}, 16'h2005)
    wr(8'hCF);  // Relative seek inward by 255, wraps modulo 256
    wr(8'h00);
    wr(8'hFF);
    seek_end();
    `CHK({st, cy}, 16'h2004)
    rd(fccu_pkg::REG_CONFIG, d);
    `CHK(d, 8'h04)
    `CHK(u_fccu_drive_model.pos, 260)
    wr(fccu_pkg::OP_CONFIGURE);
    wr(8'h00);
    wr(8'h5F);
    wr(8'hFF);
    repeat (2) @(negedge ref_clk);
    `CHK(cfg, 16'hAFFF)
    pulse(0);
    wait_hi(1, 60);
    `CHK(n inside {[12:40]}, 1'b1)
    pulse(3);
    `CHK({disk_dma_request, irq}, 2'b10)
    pulse(4);
    `CHK(disk_dma_request, 1'b0)
    pulse(1);
    repeat (200) @(negedge ref_clk);
    `CHK(head_load, 1'b1)
    repeat (100) @(negedge ref_clk);
    `CHK(head_load, 1'b0)
    pulse(2);
    `CHK(irq, 1'b1)
    @(posedge ref_clk);
    cyl <= 8'h00;
    pulse(0);
    wait_hi(1, 600);
    rd(fccu_pkg::REG_CONFIG, d);
    `CHK(d, 8'h00)
    boot();
    wr(fccu_pkg::OP_SPECIFY);
    wr(8'hF1);
    wr(8'h03);
    repeat (2) @(negedge ref_clk);
    `CHK(cfg.pio_transfer_select, 1'b1)
    pulse(0);
    wait_hi(1, 60);
    pulse(3);
    `CHK({irq, host_transfer_ready, disk_dma_request}, 3'b110)
    final_report();
  end
endmodule : fccu_top_tb
